// File: io_segment_descriptor_decode.sv
// Purpose: Segment descriptor register and I/O load/store steering onto the expansion bus
// Assumes: One request at a time; REQ held until REQ_DONE; inputs synchronous to SYS_CLK
// Notes: APB answers one cycle into the access phase; all outputs registered
// Contract
// R1 - Type 0 to memory, 1 to I/O
// R2 - I/O meaning only when selected here
// R3 - Key 0 for supervisor, 1 for user
// R4 - Reserved descriptor bits written as zero
// R5 - Answer selectors 0x20 to 0x23 by strap
// R6 - Valid target only with card-selected feedback
// R7 - Check bit clear: complete without response
// R8 - Check set, no response: interrupt, error code
// R9 - Split wide access, increment per bit 13
// R10 - Bus memory always increments address
// R11 - Software should set increment bit
// R12 - Bit 24 enters control-space mode
// R13 - Legacy mode only without control space
// R14 - Bypass set skips translation checking
// R15 - Bypass clear enables authority checking
// R16 - Bypass ignored in control space
// R17 - Standard address joins extent and EA
// R18 - Standard mode when T=1, I=0, M=0
// R19 - User control-space access raises interrupt
// R20 - Bit 0 is most significant
`timescale 1ns/10ps
module io_segment_descriptor_decode
  import io_seg_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [1:0] STRAP_SEL,
  input io_req_t REQ,
  output logic REQ_DONE,
  output logic REQ_DSI,
  output logic SYS_MEM_ROUTE,
  output logic BUS_STB,
  output logic BUS_WRITE,
  output logic [31:0] BUS_ADDR,
  input wire logic BUS_ACK,
  input wire logic BUS_CSFB,
  output logic CTRL_SPACE,
  output logic LEGACY_MODE,
  output logic XLATE_EN,
  output logic USER_STATE
);
  desc_fields_t f;
  desc_fields_t f_q, f_d;
  logic [31:0] desc_q, desc_d;
  logic [3:0] err_q, err_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  seq_state_t state_q, state_d;
  logic [2:0] beats_q, beats_d;
  logic [2:0] step_q, step_d;
  logic step_en_q, step_en_d;
  logic write_q, write_d;
  logic [31:0] addr_q, addr_d;
  logic done_q, done_d, dsi_q, dsi_d, sysmem_q, sysmem_d, stb_q, stb_d;
  logic ctrl_q, ctrl_d, legacy_q, legacy_d, xlate_q, xlate_d, user_q, user_d;
  logic err_set;
  logic [3:0] err_code;
  logic take, apb_hit, apb_wr, mapped;

  // R20 big-endian field split
  io_desc_fields u_fields (
    .desc(desc_q),
    .strap_sel(STRAP_SEL),
    .fields(f)
  );

  function automatic logic [2:0] beat_count(input logic [2:0] size, input logic [2:0] dev);
    if (size > dev && dev != 3'h0) begin
      return size / dev;
    end
    return BEATS_ONE;
  endfunction : beat_count

  // Done still stands at the edge where the caller sees it, so a held request must not start again there
  assign take = (state_q == ST_IDLE) && REQ.valid && !done_q;
  assign apb_hit = PSEL && PENABLE && !pready_q;
  assign apb_wr = PSEL && PENABLE && pready_q && PWRITE;
  assign mapped = (PADDR == OFS_DESC) || (PADDR == OFS_STATUS) || (PADDR == OFS_MODE);

  // Register file and APB answer
  always_comb begin
    desc_d = desc_q;
    err_d = err_q;
    prdata_d = prdata_q;
    pready_d = apb_hit;
    pslverr_d = apb_hit && !mapped;
    if (apb_hit) begin
      case (PADDR)
        OFS_DESC: prdata_d = desc_q;
        OFS_STATUS: prdata_d = {28'h000_0000, err_q};
        OFS_MODE: prdata_d = {16'h0000, state_q, 1'b0, f_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    if (apb_wr && PADDR == OFS_DESC) begin
      // R4 reserved positions forced low
      desc_d = PWDATA & DESC_WMASK;
    end
    // Any status write clears; a new error in the same cycle wins
    if (apb_wr && PADDR == OFS_STATUS) begin
      err_d = ERR_NONE;
    end
    if (err_set) begin
      err_d = err_code;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      desc_q <= DESC_RST;
      err_q <= ERR_NONE;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      desc_q <= desc_d;
      err_q <= err_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Request sequencer
  always_comb begin
    state_d = state_q;
    f_d = f_q;
    beats_d = beats_q;
    step_d = step_q;
    step_en_d = step_en_q;
    write_d = write_q;
    addr_d = addr_q;
    done_d = 1'b0;
    dsi_d = 1'b0;
    sysmem_d = 1'b0;
    stb_d = 1'b0;
    ctrl_d = ctrl_q;
    legacy_d = legacy_q;
    xlate_d = xlate_q;
    user_d = user_q;
    err_set = 1'b0;
    err_code = ERR_NONE;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          f_d = f;
          write_d = REQ.write;
          beats_d = beat_count(REQ.size, REQ.dev_width);
          step_d = REQ.dev_width;
          // R9 R10 increment choice
          step_en_d = f.incr || REQ.is_mem;
          // R12 R13 mode flags
          ctrl_d = f.ctrl;
          legacy_d = f.legacy;
          // R14 R15 R16 translation gate
          xlate_d = !f.bypass;
          user_d = f.user;
          // R17 R18 address forming
          if (f.std_mode) begin
            addr_d = {f.bus_memory_extent, REQ.ea[27:0]};
          end else if (f.legacy) begin
            addr_d = {LEGACY_TOP, REQ.ea[23:0]};
          end else begin
            addr_d = REQ.ea;
          end
          state_d = ST_END;
          if (!f.io_sel) begin
            // R1 system memory route
            sysmem_d = 1'b1;
          end else if (!f.mine) begin
            // R2 another controller owns it
            sysmem_d = 1'b0;
          end else if (f.ctrl && f.user) begin
            // R19 privileged space refused
            dsi_d = 1'b1;
            err_set = 1'b1;
            err_code = ERR_INVALID_OP;
          end else begin
            state_d = ST_ISSUE;
          end
        end
      end
      ST_ISSUE: begin
        stb_d = 1'b1;
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (BUS_ACK) begin
          // R6 R8 no feedback with checking on
          if (f_q.addr_chk && !BUS_CSFB) begin
            dsi_d = 1'b1;
            err_set = 1'b1;
            err_code = ERR_CSFB;
            state_d = ST_END;
          end else if (beats_q == BEATS_ONE) begin
            // R7 completes regardless of feedback
            state_d = ST_END;
          end else begin
            // R9 next narrower cycle
            beats_d = beats_q - BEATS_ONE;
            if (step_en_q) begin
              addr_d = addr_q + {29'h0000_0000, step_q};
            end
            state_d = ST_ISSUE;
          end
        end
      end
      ST_END: begin
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= ST_IDLE;
      f_q <= '0;
      beats_q <= 3'h0;
      step_q <= 3'h0;
      step_en_q <= 1'b0;
      write_q <= 1'b0;
      addr_q <= 32'h0000_0000;
      done_q <= 1'b0;
      dsi_q <= 1'b0;
      sysmem_q <= 1'b0;
      stb_q <= 1'b0;
      ctrl_q <= 1'b0;
      legacy_q <= 1'b0;
      xlate_q <= 1'b1;
      user_q <= 1'b0;
    end else begin
      state_q <= state_d;
      f_q <= f_d;
      beats_q <= beats_d;
      step_q <= step_d;
      step_en_q <= step_en_d;
      write_q <= write_d;
      addr_q <= addr_d;
      done_q <= done_d;
      dsi_q <= dsi_d;
      sysmem_q <= sysmem_d;
      stb_q <= stb_d;
      ctrl_q <= ctrl_d;
      legacy_q <= legacy_d;
      xlate_q <= xlate_d;
      user_q <= user_d;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign REQ_DONE = done_q;
  assign REQ_DSI = dsi_q;
  assign SYS_MEM_ROUTE = sysmem_q;
  assign BUS_STB = stb_q;
  assign BUS_WRITE = write_q;
  assign BUS_ADDR = addr_q;
  assign CTRL_SPACE = ctrl_q;
  assign LEGACY_MODE = legacy_q;
  assign XLATE_EN = xlate_q;
  assign USER_STATE = user_q;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  sequence s_beat_end;
    state_q == ST_WAIT && BUS_ACK;
  endsequence

  sequence s_refuse;
    dsi_q && state_q == ST_END ##1 done_q;
  endsequence

  a_sys_route: assert property (take && !f.io_sel |=> sysmem_q && !stb_q ##1 done_q) // R1
    else $error("system memory request not routed");
  a_foreign_quiet: assert property (take && f.io_sel && !f.mine |=> !sysmem_q && state_q == ST_END) // R2
    else $error("foreign selector handled locally");
  a_selector_hit: assert property (take && f.mine && !f.ctrl |=> state_q == ST_ISSUE ##1 stb_q) // R5
    else $error("own selector not served");
  a_csfb_error: assert property (s_beat_end and (f_q.addr_chk && !BUS_CSFB) |=> s_refuse) // R8
    else $error("missing feedback not reported");
  a_csfb_code: assert property (s_beat_end and (f_q.addr_chk && !BUS_CSFB) |=> ##1 err_q == ERR_CSFB) // R6
    else $error("feedback error code wrong");
  a_nocheck_pass: assert property (s_beat_end and !f_q.addr_chk |=> !dsi_q) // R7
    else $error("unchecked access refused");
  a_addr_hold: assert property (s_beat_end and (beats_q > BEATS_ONE && !step_en_q) |=> addr_q == $past(addr_q)) // R9
    else $error("address moved with increment off");
  a_addr_step: assert property (s_beat_end and (beats_q > BEATS_ONE && step_en_q // R10
      && (!f_q.addr_chk || BUS_CSFB)) |=> addr_q == $past(addr_q) + {29'h0000_0000, $past(step_q)})
    else $error("address not incremented");
  a_ctrl_user: assert property (take && f.mine && f.ctrl && f.user |=> s_refuse ##0 err_q == ERR_INVALID_OP) // R19
    else $error("user control-space access allowed");
  a_std_addr: assert property (take && f.mine && f.std_mode && !f.user |=> BUS_ADDR[31:28] == $past(f.bus_memory_extent)) // R17
    else $error("extent not joined to address");
  a_legacy_top: assert property (take && f.mine && f.legacy |=> BUS_ADDR[31:24] == LEGACY_TOP && !CTRL_SPACE) // R13
    else $error("legacy top byte not cleared");
  a_bypass_gate: assert property (take |=> XLATE_EN == !($past(f.bypass) && !CTRL_SPACE)) // R14
    else $error("translation gate wrong");
endmodule : io_segment_descriptor_decode

// File: io_seg_pkg.sv
// Purpose: Shared constants and types for the I/O segment descriptor decoder
// Assumes: Descriptor bit 0 is the most significant bit of the 32-bit word
// Notes: Register byte offsets sit on an APB slave with 12-bit address
package io_seg_pkg;
  localparam logic [11:0] OFS_DESC = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_MODE = 12'h008;
  localparam logic [31:0] DESC_RST = 32'h0000_0000;
  // Reserved positions 2,3,14..23,27 are held at zero
  localparam logic [31:0] DESC_WMASK = 32'hCFFC_00EF;
  localparam int BIT_TYPE = 0;
  localparam int BIT_PRIV = 1;
  localparam int BIT_SEL_HI = 4;
  localparam int BIT_ACHK = 12;
  localparam int BIT_INCR = 13;
  localparam int BIT_CTRL = 24;
  localparam int BIT_LEGACY = 25;
  localparam int BIT_BYPASS = 26;
  localparam int BIT_EXT_HI = 28;
  localparam logic [7:0] SELECTOR_BASE = 8'h20;
  localparam logic [7:0] LEGACY_TOP = 8'h00;
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_INVALID_OP = 4'h1;
  localparam logic [3:0] ERR_CSFB = 4'h9;
  localparam logic [2:0] BEATS_ONE = 3'h1;

  typedef struct packed {
    logic io_sel;
    logic mine;
    logic user;
    logic addr_chk;
    logic incr;
    logic ctrl;
    logic legacy;
    logic bypass;
    logic std_mode;
    logic [3:0] bus_memory_extent;
  } desc_fields_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic is_mem;
    logic [31:0] ea;
    logic [2:0] size;
    logic [2:0] dev_width;
  } io_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT = 2'b11,
    ST_END = 2'b10
  } seq_state_t;

  // Big-endian bit n of the descriptor
  function automatic logic dbit(input logic [31:0] d, input int n);
    return d[31 - n];
  endfunction : dbit
endpackage : io_seg_pkg

// File: io_desc_fields.sv
// Purpose: Splits the segment descriptor into its control fields
// Assumes: Strap value is static while requests are served
// Notes: Pure combinational decode
`timescale 1ns/10ps
module io_desc_fields
  import io_seg_pkg::*;
(
  input wire logic [31:0] desc,
  input wire logic [1:0] strap_sel,
  output desc_fields_t fields
);
  logic [7:0] sel;

  always_comb begin
    sel = desc[31 - BIT_SEL_HI -: 8];
    fields.io_sel = dbit(desc, BIT_TYPE);
    // R5 selector match
    fields.mine = fields.io_sel && (sel == (SELECTOR_BASE + {6'h00, strap_sel}));
    fields.user = dbit(desc, BIT_PRIV);
    fields.addr_chk = dbit(desc, BIT_ACHK);
    fields.incr = dbit(desc, BIT_INCR);
    fields.ctrl = dbit(desc, BIT_CTRL);
    // R13 legacy only outside control space
    fields.legacy = dbit(desc, BIT_LEGACY) && !fields.ctrl;
    // R16 bypass ignored in control space
    fields.bypass = dbit(desc, BIT_BYPASS) && !fields.ctrl;
    // R18 standard mode select
    fields.std_mode = fields.io_sel && !fields.ctrl && !dbit(desc, BIT_LEGACY);
    fields.bus_memory_extent = desc[31 - BIT_EXT_HI -: 4];
  end
endmodule : io_desc_fields

// File: io_bus_target.sv
// Purpose: Expansion bus target answering each bus cycle strobe
// Assumes: One bus cycle outstanding at a time
// Notes: Answer delay and presence are set by the bench
`timescale 1ns/10ps
module io_bus_target (
  input wire logic clk,
  input wire logic nrst,
  input wire logic stb,
  input wire logic present,
  input wire logic [3:0] lat,
  output logic ack,
  output logic csfb
);
  logic busy_q;
  logic [3:0] cnt_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      ack <= 1'b0;
      csfb <= 1'b0;
    end else begin
      ack <= 1'b0;
      // Feedback is meaningless between answers, so it toggles there
      csfb <= ~csfb;
      if (stb) begin
        busy_q <= 1'b1;
        cnt_q <= lat;
      end else if (busy_q && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        ack <= 1'b1;
        csfb <= present;
      end
    end
  end
endmodule : io_bus_target

// File: io_segment_descriptor_decode_bench.sv
// Purpose: Self-checking bench for the segment descriptor decoder
// Assumes: Strap at 0 except in two routing runs, so mostly only selector 0x20 is ours
// Notes: Bus target delay is raised once to cover slow answers
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module io_segment_descriptor_decode_bench;
  import io_seg_pkg::*;
  logic SYS_CLK = 0, NRST = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, pres = 1;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, BUS_ADDR, rd, adr[8];
  logic PREADY, PSLVERR, REQ_DONE, REQ_DSI, SYS_MEM_ROUTE, BUS_STB, BUS_WRITE, BUS_ACK, BUS_CSFB;
  logic CTRL_SPACE, LEGACY_MODE, XLATE_EN, USER_STATE, er, dsi, mr, wr = 1'b1;
  logic [1:0] STRAP_SEL = 2'h0;
  logic [3:0] lat = 4'h0;
  logic [7:0] fs[3] = '{8'h21, 8'h24, 8'h1F};
  logic [31:0] ea = 32'h0123_4560;
  io_req_t REQ = '0;
  int fails = 0, comparisons = 0, nst;
  always #4 SYS_CLK = ~SYS_CLK;
  io_segment_descriptor_decode dut (.SYS_CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .STRAP_SEL, .REQ, .REQ_DONE, .REQ_DSI, .SYS_MEM_ROUTE, .BUS_STB, .BUS_WRITE,
    .BUS_ADDR, .BUS_ACK, .BUS_CSFB, .CTRL_SPACE, .LEGACY_MODE, .XLATE_EN, .USER_STATE);
  io_bus_target tgt (.clk(SYS_CLK), .nrst(NRST), .stb(BUS_STB), .present(pres), .lat(lat), .ack(BUS_ACK),
    .csfb(BUS_CSFB));
  // Descriptor with bit 0 leftmost; reserved places always zero
  function automatic logic [31:0] dsc(input logic t, k, a, i, c, l, b, input logic [7:0] s);
    return {t, k, 2'h0, s, a, i, 10'h000, c, l, b, 1'h0, 4'hA};
  endfunction : dsc
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      t++;
    end while (PREADY !== 1'b1 && t < 50);
    if (t >= 50) fails++;
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic run(input logic [31:0] d, input logic m, input logic [2:0] sz, dw);
    int t;
    t = 0;
    apb(1'b1, OFS_DESC, d);
    nst = 0;
    dsi = 0;
    mr = 0;
    REQ <= '{valid: 1'b1, write: wr, is_mem: m, ea: ea, size: sz, dev_width: dw};
    do begin
      @(posedge SYS_CLK);
      t++;
      if (BUS_STB === 1'b1) begin
        adr[nst] = BUS_ADDR;
        nst++;
      end
      dsi |= REQ_DSI === 1'b1;
      mr |= SYS_MEM_ROUTE === 1'b1;
    end while (REQ_DONE !== 1'b1 && t < 300);
    if (t >= 300) fails++;
    REQ.valid <= 1'b0;
  endtask : run
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    #200000;
    fails++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge SYS_CLK);
    NRST <= 1'b1;
    `CHK(XLATE_EN, 1'b1)
    apb(1'b0, OFS_DESC, 32'h0);
    `CHK(rd, DESC_RST)
    apb(1'b1, OFS_DESC, 32'hFFFF_FFFF);
    apb(1'b0, OFS_DESC, 32'h0);
    `CHK(rd, 32'hCFFC_00EF)
    apb(1'b0, 12'h00C, 32'h0);
    `CHK({er, rd}, 33'h1_0000_0000)
    $display("test registers done");
    run(dsc(0, 0, 0, 1, 0, 0, 0, 8'h20), 1'b0, 3'h4, 3'h4);
    `CHK({mr, nst[3:0]}, 5'h10)
    foreach (fs[i]) begin
      run(dsc(1, 0, 0, 1, 0, 0, 0, fs[i]), 1'b0, 3'h4, 3'h4);
      `CHK({dsi, mr, nst[3:0]}, 6'h00)
    end
    STRAP_SEL <= 2'h3;
    run(dsc(1, 0, 0, 1, 0, 0, 0, 8'h23), 1'b0, 3'h4, 3'h4);
    `CHK({dsi, mr, nst[3:0]}, 6'h01)
    run(dsc(1, 0, 0, 1, 0, 0, 0, 8'h20), 1'b0, 3'h4, 3'h4);
    `CHK(nst, 0)
    STRAP_SEL <= 2'h0;
    $display("test routing done");
    run(dsc(1, 1, 0, 1, 0, 0, 0, 8'h20), 1'b0, 3'h4, 3'h2);
    `CHK(nst, 2)
    `CHK(adr[0], 32'hA123_4560)
    `CHK(adr[1], 32'hA123_4562)
    `CHK({USER_STATE, XLATE_EN, CTRL_SPACE, LEGACY_MODE, BUS_WRITE}, 5'h19)
    lat <= 4'h3;
    run(dsc(1, 0, 0, 1, 0, 0, 0, 8'h20), 1'b0, 3'h4, 3'h1);
    `CHK(adr[3], 32'hA123_4563)
    lat <= 4'h0;
    run(dsc(1, 0, 0, 0, 0, 0, 0, 8'h20), 1'b0, 3'h4, 3'h2);
    `CHK(adr[1], 32'hA123_4560)
    run(dsc(1, 0, 0, 0, 0, 0, 0, 8'h20), 1'b1, 3'h4, 3'h2);
    `CHK(adr[1], 32'hA123_4562)
    $display("test sizing done");
    pres <= 1'b0;
    run(dsc(1, 0, 1, 1, 0, 0, 0, 8'h20), 1'b0, 3'h4, 3'h2);
    `CHK({dsi, nst[3:0]}, 5'h11)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[3:0], ERR_CSFB)
    apb(1'b1, OFS_STATUS, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[3:0], ERR_NONE)
    run(dsc(1, 0, 0, 1, 0, 0, 0, 8'h20), 1'b0, 3'h4, 3'h2);
    `CHK({dsi, nst[3:0]}, 5'h02)
    pres <= 1'b1;
    $display("test feedback done");
    run(dsc(1, 1, 0, 1, 1, 0, 0, 8'h20), 1'b0, 3'h4, 3'h4);
    `CHK({dsi, nst[3:0]}, 5'h10)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[3:0], ERR_INVALID_OP)
    apb(1'b1, OFS_STATUS, 32'h0);
    run(dsc(1, 0, 0, 1, 1, 1, 1, 8'h20), 1'b0, 3'h4, 3'h4);
    `CHK({USER_STATE, CTRL_SPACE, LEGACY_MODE, XLATE_EN}, 4'h5)
    `CHK(adr[0], ea)
    wr = 1'b0;
    run(dsc(1, 0, 0, 1, 0, 1, 0, 8'h20), 1'b0, 3'h4, 3'h4);
    `CHK(LEGACY_MODE, 1'b1)
    `CHK(adr[0], 32'h0023_4560)
    `CHK(BUS_WRITE, 1'b0)
    wr = 1'b1;
    run(dsc(1, 0, 0, 1, 0, 0, 1, 8'h20), 1'b0, 3'h4, 3'h4);
    `CHK(XLATE_EN, 1'b0)
    apb(1'b0, OFS_MODE, 32'h0);
    `CHK(rd, 32'h0000_193A)
    $display("test modes done");
    summarize();
  end
endmodule : io_segment_descriptor_decode_bench
